//--- rtl/io_port_regs.vh
// Register offsets, reset values and port addresses of the I/O port block
// Assumes an 8-bit configuration register space addressed by the core
`ifndef IO_PORT_REGS_VH
`define IO_PORT_REGS_VH

// ----------------------------------------------------------------------------
// Configuration register offsets
// ----------------------------------------------------------------------------
`define PA_PULLUP_OFS   8'h18
`define PA_OPTION_OFS   8'h19
`define PA_DIR_OFS      8'h1a
`define PA_FUNC_OFS     8'h1b
`define PB_PULLUP_OFS   8'h1c
`define PB_OPTION_OFS   8'h1d
`define PB_DIR_OFS      8'h1e
`define PB_FUNC_OFS     8'h1f
`define PC_PULLUP_OFS   8'h20
`define PC_OPTION_OFS   8'h21
`define PC_DIR_OFS      8'h22
`define PC_FUNC_OFS     8'h23
`define INTERRUPT_POLARITY_REGISTER_OFS     8'h24

// ----------------------------------------------------------------------------
// Port input and output addresses
// ----------------------------------------------------------------------------
`define PORT_A_ADDR     8'h00
`define PORT_B_ADDR     8'h01
`define PORT_C_ADDR     8'h02

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define CFG_RESET       8'h00
`define POL_RESET       8'h00
`define POL_A_BIT       0
`define POL_B_BIT       1
`define NMI_PIN         7
`define SDA_PIN         1
`define SCL_PIN         0
`define ALT_OUT_A       8'h47
`define ALT_IN_A        8'hbb

`endif

//--- rtl/io_pin_cell.v
// One port pin: mode decode, output drivers, pull-up and input sampling
// Assumes latched pull-up, option and direction bits and an asynchronous pin input
`timescale 1ns/1ps

module io_pin_cell (
  input  wire clk,
  input  wire rst,
  input  wire pu,
  input  wire opt,
  input  wire dir,
  input  wire func,
  input  wire alt_out,
  input  wire out_bit,
  input  wire pin_in,
  input  wire int_ok,
  output reg  pin_out_r,
  output reg  pin_oe_r,
  output reg  pull_r,
  output reg  weak_r,
  output reg  sync_r,
  output wire int_mode,
  output wire in_mode
);

  reg  meta_r;
  wire drv_val;
  wire drv_en;

  // ----------------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------------
  assign in_mode  = ~dir;
  assign int_mode = ~dir & opt & int_ok & ~func;
  // Alternate output only with direction set
  assign drv_val  = (func & dir) ? alt_out : out_bit;
  // Open drain drives only a low level
  assign drv_en   = dir & (~(opt & ~pu) | ~drv_val);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
      pull_r    <= 1'b0;
      weak_r    <= 1'b0;
      meta_r    <= 1'b0;
      sync_r    <= 1'b0;
    end else begin
      pin_out_r <= drv_val;
      pin_oe_r  <= drv_en;
      pull_r    <= pu & ~(dir & opt);
      weak_r    <= pu & dir & opt;
      meta_r    <= pin_in;
      sync_r    <= meta_r;
    end
  end

endmodule

//--- rtl/multi_mode_io_port.v
// Three 8-bit multi-mode I/O ports with configuration, data and interrupt logic
// Assumes core-driven configuration and port access strobes on the same clock
//
// Functional notes
// - Reset leaves all pins high-impedance inputs
// - Input modes from pull-up and option bits
// - Output modes from pull-up and option bits
// - Pull-up and option applied on direction write
// - Each bit controls its own pin only
// - Input read returns pin levels, ports 0-2
// - Output pins read back the output buffer
// - Output write updates buffer, drives pins
// - Output bits ignored on input pins
// - Only ports A and B interrupt
// - Per-port interrupt is OR of pins
// - Interrupt pin levels stay readable
// - Polarity register selects interrupt edge
// - Function bit picks I/O or peripheral
// - Direction picks input or output alternate
// - NMI needs pin A7 alternate and input
// - I2C unit overrides pin mode
// - Port A alternate functions per bit
`timescale 1ns/1ps
`include "io_port_regs.vh"

module multi_mode_io_port (
  input  wire        clk,
  input  wire        rst,
  // Configuration register access
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata_r,
  // Port input read and output write
  input  wire        port_rd,
  input  wire        port_wr,
  input  wire [7:0]  port_addr,
  input  wire [7:0]  port_wdata,
  output reg  [7:0]  port_rdata_r,
  // Pins
  input  wire [23:0] pin_in,
  output wire [23:0] pin_out,
  output wire [23:0] pin_oe,
  output wire [23:0] pin_pull,
  output wire [23:0] pin_weak,
  // Peripheral side
  input  wire [23:0] alt_out,
  output reg  [23:0] alt_in_r,
  input  wire        i2c_own,
  input  wire        i2c_sda_low,
  input  wire        i2c_scl_low,
  output reg         nmi_req_r,
  output reg         irq_a_r,
  output reg         irq_b_r,
  input  wire        irq_a_ack,
  input  wire        irq_b_ack
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Written pull-up and option, waiting for a direction write
  reg  [7:0]  pu_wr_r    [0:2];
  reg  [7:0]  opt_wr_r   [0:2];
  reg  [7:0]  dir_r      [0:2];
  reg  [7:0]  func_r     [0:2];
  // Settings the pin cells use
  reg  [7:0]  pu_act_r   [0:2];
  reg  [7:0]  opt_act_r  [0:2];
  reg  [7:0]  out_buf_r  [0:2];
  reg  [7:0]  pol_r;
  // Previous synchronised level of ports A and B
  reg  [15:0] int_prev_r;

  wire [23:0] pu_v;
  wire [23:0] opt_v;
  wire [23:0] dir_v;
  wire [23:0] func_v;
  wire [23:0] obuf_v;
  wire [23:0] ok_v;
  wire [23:0] alt_v;
  wire [23:0] alt_ok_out;
  wire [23:0] alt_ok_in;
  wire [23:0] sync_v;
  wire [23:0] intm_v;
  wire [23:0] inm_v;
  wire [23:0] cell_oe;
  wire [23:0] cell_out;
  wire [23:0] cell_pull;
  wire [23:0] cell_weak;
  wire [23:0] rd_v;
  wire [15:0] edge_v;
  wire [15:0] pol_v;
  wire [15:0] rise_v;
  wire [15:0] fall_v;
  wire        edge_a;
  wire        edge_b;

  integer i;

  // ----------------------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------------------
  // Pull-up and option reach the pins only through a direction write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        pu_wr_r[i]   <= `CFG_RESET;
        opt_wr_r[i]  <= `CFG_RESET;
        dir_r[i]     <= `CFG_RESET;
        func_r[i]    <= `CFG_RESET;
        pu_act_r[i]  <= `CFG_RESET;
        opt_act_r[i] <= `CFG_RESET;
      end
      pol_r <= `POL_RESET;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `PA_PULLUP_OFS: pu_wr_r[0] <= cfg_wdata;
        `PA_OPTION_OFS: opt_wr_r[0] <= cfg_wdata;
        `PA_DIR_OFS: begin
          dir_r[0]     <= cfg_wdata;
          pu_act_r[0]  <= pu_wr_r[0];
          opt_act_r[0] <= opt_wr_r[0];
        end
        `PA_FUNC_OFS:   func_r[0] <= cfg_wdata;
        `PB_PULLUP_OFS: pu_wr_r[1] <= cfg_wdata;
        `PB_OPTION_OFS: opt_wr_r[1] <= cfg_wdata;
        `PB_DIR_OFS: begin
          dir_r[1]     <= cfg_wdata;
          pu_act_r[1]  <= pu_wr_r[1];
          opt_act_r[1] <= opt_wr_r[1];
        end
        `PB_FUNC_OFS:   func_r[1] <= cfg_wdata;
        `PC_PULLUP_OFS: pu_wr_r[2] <= cfg_wdata;
        `PC_OPTION_OFS: opt_wr_r[2] <= cfg_wdata;
        `PC_DIR_OFS: begin
          dir_r[2]     <= cfg_wdata;
          pu_act_r[2]  <= pu_wr_r[2];
          opt_act_r[2] <= opt_wr_r[2];
        end
        `PC_FUNC_OFS:   func_r[2] <= cfg_wdata;
        `INTERRUPT_POLARITY_REGISTER_OFS:   pol_r <= cfg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration read back
  // ----------------------------------------------------------------------------
  // Pull-up and option read back as written, applied or not
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_r <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `PA_PULLUP_OFS: cfg_rdata_r <= pu_wr_r[0];
        `PA_OPTION_OFS: cfg_rdata_r <= opt_wr_r[0];
        `PA_DIR_OFS:    cfg_rdata_r <= dir_r[0];
        `PA_FUNC_OFS:   cfg_rdata_r <= func_r[0];
        `PB_PULLUP_OFS: cfg_rdata_r <= pu_wr_r[1];
        `PB_OPTION_OFS: cfg_rdata_r <= opt_wr_r[1];
        `PB_DIR_OFS:    cfg_rdata_r <= dir_r[1];
        `PB_FUNC_OFS:   cfg_rdata_r <= func_r[1];
        `PC_PULLUP_OFS: cfg_rdata_r <= pu_wr_r[2];
        `PC_OPTION_OFS: cfg_rdata_r <= opt_wr_r[2];
        `PC_DIR_OFS:    cfg_rdata_r <= dir_r[2];
        `PC_FUNC_OFS:   cfg_rdata_r <= func_r[2];
        `INTERRUPT_POLARITY_REGISTER_OFS:   cfg_rdata_r <= pol_r;
        default:        cfg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Output buffers
  // ----------------------------------------------------------------------------
  // Buffer is written whatever the pin direction; inputs ignore it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        out_buf_r[i] <= 8'h00;
      end
    end else if (port_wr) begin
      case (port_addr)
        `PORT_A_ADDR: out_buf_r[0] <= port_wdata;
        `PORT_B_ADDR: out_buf_r[1] <= port_wdata;
        `PORT_C_ADDR: out_buf_r[2] <= port_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------------------
  assign pu_v   = {pu_act_r[2], pu_act_r[1], pu_act_r[0]};
  assign opt_v  = {opt_act_r[2], opt_act_r[1], opt_act_r[0]};
  assign dir_v  = {dir_r[2], dir_r[1], dir_r[0]};
  assign func_v = {func_r[2], func_r[1], func_r[0]};
  assign obuf_v = {out_buf_r[2], out_buf_r[1], out_buf_r[0]};
  assign ok_v   = {8'h00, 8'hff, 8'hff};
  // Port A pins carry only their listed peripheral directions
  assign alt_ok_out = {16'hffff, `ALT_OUT_A};
  assign alt_ok_in  = {16'hffff, `ALT_IN_A};
  assign alt_v      = alt_out & alt_ok_out;

  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : pin_g
      io_pin_cell u_cell (
        .clk       (clk),
        .rst       (rst),
        .pu        (pu_v[g]),
        .opt       (opt_v[g]),
        .dir       (dir_v[g]),
        .func      (func_v[g]),
        .alt_out   (alt_v[g]),
        .out_bit   (obuf_v[g]),
        .pin_in    (pin_in[g]),
        .int_ok    (ok_v[g]),
        .pin_out_r (cell_out[g]),
        .pin_oe_r  (cell_oe[g]),
        .pull_r    (cell_pull[g]),
        .weak_r    (cell_weak[g]),
        .sync_r    (sync_v[g]),
        .int_mode  (intm_v[g]),
        .in_mode   (inm_v[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Pin output stage, I2C override on port A pins 1 and 0
  // ----------------------------------------------------------------------------
  reg  [23:0] pin_out_r;
  reg  [23:0] pin_oe_r;
  reg  [23:0] pin_pull_r;
  reg  [23:0] pin_weak_r;
  wire [1:0]  i2c_oe;
  wire [1:0]  own_mask;

  // I2C unit only pulls low; no high level and no pulls while it owns
  assign i2c_oe   = {i2c_sda_low, i2c_scl_low};
  assign own_mask = {2{~i2c_own}};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_r  <= 24'h000000;
      pin_oe_r   <= 24'h000000;
      pin_pull_r <= 24'h000000;
      pin_weak_r <= 24'h000000;
    end else begin
      pin_out_r  <= {cell_out[23:2], cell_out[1:0] & own_mask};
      pin_oe_r   <= {cell_oe[23:2], i2c_own ? i2c_oe : cell_oe[1:0]};
      pin_pull_r <= {cell_pull[23:2], cell_pull[1:0] & own_mask};
      pin_weak_r <= {cell_weak[23:2], cell_weak[1:0] & own_mask};
    end
  end

  assign pin_out  = pin_out_r;
  assign pin_oe   = pin_oe_r;
  assign pin_pull = pin_pull_r;
  assign pin_weak = pin_weak_r;

  // ----------------------------------------------------------------------------
  // Port input read
  // ----------------------------------------------------------------------------
  // Output pins return the buffer, all other pins their synchronised level
  assign rd_v = (sync_v & ~dir_v) | (obuf_v & dir_v);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_rdata_r <= 8'h00;
    end else if (port_rd) begin
      case (port_addr)
        `PORT_A_ADDR: port_rdata_r <= rd_v[7:0];
        `PORT_B_ADDR: port_rdata_r <= rd_v[15:8];
        `PORT_C_ADDR: port_rdata_r <= rd_v[23:16];
        default:      port_rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Alternate inputs
  // ----------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_in_r <= 24'h000000;
    end else begin
      alt_in_r <= sync_v & func_v & inm_v & alt_ok_in;
    end
  end

  // ----------------------------------------------------------------------------
  // Non-maskable request from port A pin 7
  // ----------------------------------------------------------------------------
  // Only an alternate-function input pin may raise it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_req_r <= 1'b0;
    end else begin
      nmi_req_r <= sync_v[`NMI_PIN] & func_v[`NMI_PIN]
                   & inm_v[`NMI_PIN];
    end
  end

  // ----------------------------------------------------------------------------
  // Port interrupts
  // ----------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_prev_r <= 16'h0000;
    end else begin
      int_prev_r <= sync_v[15:0];
    end
  end

  // Polarity bit 1 selects the rising edge, 0 the falling edge
  assign pol_v  = {{8{pol_r[`POL_B_BIT]}}, {8{pol_r[`POL_A_BIT]}}};
  assign rise_v = sync_v[15:0] & ~int_prev_r;
  assign fall_v = ~sync_v[15:0] & int_prev_r;
  assign edge_v = intm_v[15:0] & ((pol_v & rise_v) | (~pol_v & fall_v));
  assign edge_a = |edge_v[7:0];
  assign edge_b = |edge_v[15:8];

  // Edge beats acknowledge in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      irq_a_r <= edge_a | (irq_a_r & ~irq_a_ack);
      irq_b_r <= edge_b | (irq_b_r & ~irq_b_ack);
    end
  end

endmodule

//--- tb/multi_mode_io_port_asserts.sv
// Checker for the I/O port block: pin, read and interrupt timing
// Assumes binding onto the port block, all signals on clk
`timescale 1ns/1ps

module multi_mode_io_port_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_rdata_r,
  input wire logic        port_rd,
  input wire logic        port_wr,
  input wire logic [7:0]  port_addr,
  input wire logic [7:0]  port_rdata_r,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pull,
  input wire logic [23:0] pin_weak,
  input wire logic        irq_a_r,
  input wire logic        irq_b_r,
  input wire logic        irq_a_ack,
  input wire logic        irq_b_ack
);
  logic [7:0] prev_a, prev_b;
  logic [2:0] age_a, age_b;

  // Cycles since a port A or B pin last moved, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_a <= 8'h00;
      prev_b <= 8'h00;
      age_a  <= 3'h7;
      age_b  <= 3'h7;
    end else begin
      prev_a <= pin_in[7:0];
      prev_b <= pin_in[15:8];
      age_a  <= (pin_in[7:0] != prev_a) ? 3'h0 : ((age_a == 3'h7) ? age_a : age_a + 3'h1);
      age_b  <= (pin_in[15:8] != prev_b) ? 3'h0 : ((age_b == 3'h7) ? age_b : age_b + 3'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_quiet: assert property ($fell(rst) |-> pin_oe == 24'h0 && pin_pull == 24'h0)
    else $error("pins not quiet after reset");
  chk_port_refuse: assert property (port_rd && port_addr > 8'h02 |=> port_rdata_r == 8'h00)
    else $error("unmapped port read not zero");
  chk_cfg_refuse: assert property (cfg_rd && (cfg_addr < 8'h18 || cfg_addr > 8'h24)
    |=> cfg_rdata_r == 8'h00)
    else $error("unmapped config read not zero");
  chk_read_hold: assert property (!port_rd |=> $stable(port_rdata_r))
    else $error("port read data moved without a read");
  chk_oe_cause: assert property ($changed(pin_oe[23:2]) |-> $past(cfg_wr, 3) || $past(port_wr, 3))
    else $error("output enable changed without a write");
  chk_pull_latch: assert property ($changed({pin_pull[23:2], pin_weak[23:2]})
    |-> $past(cfg_wr, 3) && $past(cfg_addr, 3) inside {8'h1a, 8'h1e, 8'h22})
    else $error("pull changed without a direction write");
  chk_hold_a: assert property (irq_a_r && !irq_a_ack |=> irq_a_r)
    else $error("port A request dropped before accept");
  chk_hold_b: assert property (irq_b_r && !irq_b_ack |=> irq_b_r)
    else $error("port B request dropped before accept");
  chk_cause_a: assert property ($rose(irq_a_r) |-> age_a <= 3'h5)
    else $error("port A request without a pin edge");
  chk_cause_b: assert property ($rose(irq_b_r) |-> age_b <= 3'h5)
    else $error("port B request without a pin edge");
  chk_ack_clear: assert property (irq_a_ack && age_a >= 3'h2 |=> !irq_a_r)
    else $error("port A request survived accept");

  cover property ($rose(irq_a_r));
  cover property ($rose(irq_b_r));
  cover property (cfg_wr && cfg_addr == 8'h1a);
endmodule

bind multi_mode_io_port multi_mode_io_port_asserts i_chk (
  .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_rdata_r(cfg_rdata_r), .port_rd(port_rd), .port_wr(port_wr), .port_addr(port_addr),
  .port_rdata_r(port_rdata_r), .pin_in(pin_in), .pin_oe(pin_oe), .pin_pull(pin_pull),
  .pin_weak(pin_weak), .irq_a_r(irq_a_r), .irq_b_r(irq_b_r), .irq_a_ack(irq_a_ack),
  .irq_b_ack(irq_b_ack));

//--- tb/pin_env_model.sv
// Pad model: resolves each pin from port drivers, outside sources and pulls
// Assumes outside sources drive only where their enable bit is set
`timescale 1ns/1ps

module pin_env_model (
  input  wire        clk,
  input  wire [23:0] pin_out,
  input  wire [23:0] pin_oe,
  input  wire [23:0] pin_pull,
  input  wire [23:0] pin_weak,
  input  wire [23:0] ext_en,
  input  wire [23:0] ext_val,
  output wire [23:0] pin_level
);
  reg [23:0] drift_r;

  // Undriven, unpulled pads wander every cycle
  initial drift_r = 24'h5a5a5a;
  always @(posedge clk) drift_r <= ~drift_r;

  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                   | (~pin_oe & ~ext_en & (pin_pull | pin_weak | drift_r));
endmodule

//--- tb/multi_mode_io_port_bench.sv
// Bench for the I/O port block: config, port access, interrupts, alternates
// Assumes the pad model on the pins and the checker bound in
`timescale 1ns/1ps

module multi_mode_io_port_bench;
  reg         clk, rst, cfg_wr, cfg_rd, port_rd, port_wr, i2c_own, i2c_sda_low;
  reg         i2c_scl_low, irq_a_ack, irq_b_ack;
  reg  [7:0]  cfg_addr, cfg_wdata, port_addr, port_wdata;
  reg  [23:0] alt_out, ext_en, ext_val;
  wire [7:0]  cfg_rdata_r, port_rdata_r;
  wire [23:0] pin_in, pin_out, pin_oe, pin_pull, pin_weak, alt_in_r;
  wire        nmi_req_r, irq_a_r, irq_b_r;
  integer     errors, tests_run, i;

  multi_mode_io_port i_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r),
    .port_rd(port_rd), .port_wr(port_wr), .port_addr(port_addr), .port_wdata(port_wdata),
    .port_rdata_r(port_rdata_r), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull(pin_pull), .pin_weak(pin_weak), .alt_out(alt_out), .alt_in_r(alt_in_r),
    .i2c_own(i2c_own), .i2c_sda_low(i2c_sda_low), .i2c_scl_low(i2c_scl_low),
    .nmi_req_r(nmi_req_r), .irq_a_r(irq_a_r), .irq_b_r(irq_b_r),
    .irq_a_ack(irq_a_ack), .irq_b_ack(irq_b_ack));

  pin_env_model i_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull(pin_pull),
    .pin_weak(pin_weak), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  always #25 clk = ~clk;

  // --------------------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------------------
  task check(input [47:0] seen, input [47:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task cfg_w(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      cfg_wr <= 1'b0;
    end
  endtask
  task cfg_r(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      {cfg_rd, cfg_addr} <= {1'b1, a};
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1 check(cfg_rdata_r, e);
    end
  endtask
  task port_w(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {port_wr, port_addr, port_wdata} <= {1'b1, a, d};
      @(posedge clk);
      port_wr <= 1'b0;
    end
  endtask
  task port_r(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      {port_rd, port_addr} <= {1'b1, a};
      @(posedge clk);
      port_rd <= 1'b0;
      #1 check(port_rdata_r, e);
    end
  endtask
  // Move the pads, check the requests, then accept both
  task pulse(input [23:0] v, input [1:0] e);
    begin
      @(posedge clk);
      ext_val <= v;
      cyc(6);
      check({irq_b_r, irq_a_r}, e);
      @(posedge clk);
      {irq_b_ack, irq_a_ack} <= 2'b11;
      @(posedge clk);
      {irq_b_ack, irq_a_ack} <= 2'b00;
      cyc(1);
      check({irq_b_r, irq_a_r}, 2'b00);
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    #500000;
    errors = errors + 1;
    close_out;
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {clk, rst, cfg_wr, cfg_rd, port_rd, port_wr, i2c_own, i2c_sda_low} = 8'h40;
    {i2c_scl_low, irq_a_ack, irq_b_ack} = 3'h0;
    {cfg_addr, cfg_wdata, port_addr, port_wdata} = 32'h0;
    {alt_out, ext_en, ext_val} = {24'h0, 24'hffffdd, 24'h0};
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    check({pin_oe, pin_pull}, 48'h0);
    for (i = 8'h18; i <= 8'h25; i = i + 1) cfg_r(i[7:0], 8'h00);
    cfg_w(8'h30, 8'hff);
    cfg_r(8'h30, 8'h00);
    cfg_w(8'h1b, 8'h5a);
    cfg_r(8'h1b, 8'h5a);
    cfg_w(8'h1b, 8'h00);
    @(posedge clk) ext_val <= 24'h000014;
    cfg_w(8'h18, 8'hf0);
    cfg_w(8'h19, 8'hcc);
    cyc(3);
    check(pin_pull[7:0], 8'h00);
    cfg_w(8'h1a, 8'haa);
    port_w(8'h00, 8'hff);
    cyc(3);
    check({pin_oe[6:0], pin_out[5], pin_out[1]}, 9'h08b);
    check({pin_pull[6:0], pin_weak[7]}, 8'he1);
    port_w(8'h00, 8'h00);
    cyc(3);
    check({pin_oe[6:0], pin_out[5], pin_out[1]}, 9'h0a8);
    port_r(8'h00, 8'h14);
    pulse(24'h000014, 2'b00);
    cfg_w(8'h24, 8'h01);
    pulse(24'h000054, 2'b01);
    port_r(8'h00, 8'h54);
    pulse(24'h000014, 2'b00);
    pulse(24'h000015, 2'b00);
    cfg_w(8'h24, 8'h00);
    pulse(24'h000011, 2'b01);
    cfg_w(8'h1d, 8'hff);
    cfg_w(8'h1e, 8'h00);
    cfg_w(8'h24, 8'h02);
    pulse(24'h000811, 2'b10);
    cfg_w(8'h21, 8'hff);
    cfg_w(8'h22, 8'h00);
    pulse(24'hff0811, 2'b00);
    for (i = 1; i < 3; i = i + 1) begin
      cfg_w(8'h19 + 8'h04 * i[7:0], 8'h00);
      cfg_w(8'h1a + 8'h04 * i[7:0], 8'hff);
      port_w(i[7:0], 8'ha0 | i[7:0]);
      cyc(3);
      check({pin_oe[8*i +: 8], pin_out[8*i +: 8]}, {8'hff, 8'ha0 | i[7:0]});
      port_r(i[7:0], 8'ha0 | i[7:0]);
    end
    port_r(8'h03, 8'h00);
    cfg_w(8'h18, 8'h00);
    cfg_w(8'h19, 8'h00);
    cfg_w(8'h1b, 8'h48);
    cfg_w(8'h1a, 8'h40);
    @(posedge clk) {alt_out, ext_val} <= {24'h000040, 24'hff0888};
    cyc(4);
    check({pin_out[6], alt_in_r[3], alt_in_r[6], nmi_req_r}, 4'b1100);
    @(posedge clk) alt_out <= 24'h0;
    cfg_w(8'h1a, 8'hc0);
    cfg_w(8'h1b, 8'hc8);
    cyc(4);
    check({pin_out[6], nmi_req_r}, 2'b00);
    cfg_w(8'h1a, 8'h40);
    cyc(6);
    check(nmi_req_r, 1'b1);
    @(posedge clk) {i2c_own, i2c_sda_low} <= 2'b11;
    cyc(4);
    check({pin_oe[1:0], pin_out[1]}, 3'b100);
    close_out;
  end
endmodule
